/* design/bank_decoder.sv */
// Bank decoder: full data address, target and canonical mirror address.
// Assumes bank bits and pointer come from registers of the same clock.
`timescale 1ns/1ps
module bank_decoder (
  input wire logic [1:0] bank_sel,
  input wire logic [memmap_pkg::LOCAL_W-1:0] local_addr,
  input wire logic [memmap_pkg::DATA_W-1:0] pointer,
  output memmap_pkg::data_dec_t dec
);
  import memmap_pkg::*;

  logic [DADDR_W-1:0] addr; // Effective full address
  logic [LOCAL_W-1:0] loc;  // Effective local address

  ////////////////////////////////////////////////////////////////////////
  // Direct or indirect address, then decode
  always_comb begin
    dec.indirect = (local_addr == INDIRECT_LOC);
    if (dec.indirect) begin
      // Pointer plus upper bank bit reaches all banks
      addr = {bank_sel[1], pointer};
    end else begin
      addr = {bank_sel, local_addr};
    end
    loc = addr[LOCAL_W-1:0];
    dec.full_addr = addr;
    dec.canon_addr = loc;
    // Low locations are special registers, upper ones RAM
    if (loc == INDIRECT_LOC) begin
      dec.target = TGT_NONE; // Indirect through the pointer itself reads 0
    end else if (loc < GPR_BASE) begin
      dec.target = TGT_SFR;
    end else begin
      dec.target = TGT_GPR;
    end
  end
endmodule // bank_decoder

/* design/core_memory_map.sv */
// Core memory address map: program fetch aliasing, vectors, banked data
// decode with mirrored special registers and general RAM, EEPROM pointer.
// Assumes the core issues one fetch and one data access per cycle.
`timescale 1ns/1ps
module core_memory_map #(
  parameter bit LARGE = 1'b1 // Larger variant: 2K program, 256 EEPROM
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input memmap_pkg::prog_req_t PROG_REQ,
  input wire logic INTR_TAKE,
  output logic [memmap_pkg::PC_W-1:0] PC,
  output logic [memmap_pkg::PROG_LARGE_W-1:0] PROG_ADDR,
  output logic PROG_RD,
  input wire logic [memmap_pkg::INSTR_W-1:0] PROG_WORD,
  output logic [memmap_pkg::INSTR_W-1:0] INSTR,
  input memmap_pkg::data_req_t DATA_REQ,
  output logic [memmap_pkg::DATA_W-1:0] DATA_RDATA,
  output logic [memmap_pkg::DADDR_W-1:0] DATA_FULL_ADDR,
  output logic [1:0] BANK,
  output logic [memmap_pkg::DATA_W-1:0] STATUS,
  output logic [memmap_pkg::DATA_W-1:0] POINTER,
  input wire logic EE_PTR_WR,
  input wire logic [memmap_pkg::DATA_W-1:0] EE_PTR_WDATA,
  output logic [memmap_pkg::EE_LARGE_W-1:0] EE_ADDR
);
  import memmap_pkg::*;

  localparam int PW = LARGE ? PROG_LARGE_W : PROG_SMALL_W;
  localparam int GPR_N = 96; // Bank 0 general RAM size

  // All state in one struct
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic [INSTR_W-1:0] instr;
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] pointer;
    logic [DATA_W-1:0] pclath;
    logic [DATA_W-1:0] intctl;
    logic [DATA_W-1:0] rdata;
    logic [DADDR_W-1:0] full;
    logic [EE_LARGE_W-1:0] ee_ptr;
    logic [GPR_N-1:0][DATA_W-1:0] gpr;
  } state_t;

  state_t s_q; // Registered state
  state_t s_d; // Next state
  data_dec_t dec; // Decode of the current data access
  logic [1:0] bank_sel; // Live bank select bits

  ////////////////////////////////////////////////////////////////////////
  // Bank selection from status
  assign bank_sel = {s_q.status[STATUS_BANK_HI], s_q.status[STATUS_BANK_LO]};

  bank_decoder u_dec (
    .bank_sel(bank_sel),
    .local_addr(DATA_REQ.local_addr),
    .pointer(s_q.pointer),
    .dec(dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state; program and data paths share no resource
  always_comb begin
    logic [6:0] gi;
    gi = 7'h00;
    s_d = s_q;
    // Program side
    if (INTR_TAKE) begin
      s_d.pc = INTR_VEC;
    end else if (PROG_REQ.fetch) begin
      s_d.pc = PROG_REQ.pc;
      s_d.instr = PROG_WORD;
    end
    // Data side reads: mirrored registers answer in any bank
    s_d.full = dec.full_addr;
    if (DATA_REQ.rd) begin
      s_d.rdata = 8'h00;
      if (dec.target == TGT_SFR) begin
        unique case (dec.canon_addr)
          STATUS_LOC: s_d.rdata = s_q.status;
          POINTER_LOC: s_d.rdata = s_q.pointer;
          PCLATH_LOC: s_d.rdata = s_q.pclath;
          INTCTL_LOC: s_d.rdata = s_q.intctl;
          default: s_d.rdata = 8'h00; // Peripheral registers live elsewhere
        endcase
      end else if (dec.target == TGT_GPR) begin
        // Banks alias onto one RAM; a limitation of this small map
        gi = dec.canon_addr - GPR_BASE;
        s_d.rdata = s_q.gpr[gi];
      end
    end
    // Data side writes
    if (DATA_REQ.wr) begin
      if (dec.target == TGT_SFR) begin
        unique case (dec.canon_addr)
          STATUS_LOC: s_d.status = DATA_REQ.wdata;
          POINTER_LOC: s_d.pointer = DATA_REQ.wdata;
          PCLATH_LOC: s_d.pclath = DATA_REQ.wdata;
          INTCTL_LOC: s_d.intctl = DATA_REQ.wdata;
          default: ;
        endcase
      end else if (dec.target == TGT_GPR) begin
        gi = dec.canon_addr - GPR_BASE;
        s_d.gpr[gi] = DATA_REQ.wdata;
      end
    end
    // EEPROM pointer, never in the direct map
    if (EE_PTR_WR) begin
      s_d.ee_ptr = LARGE ? EE_PTR_WDATA : {1'b0, EE_PTR_WDATA[EE_SMALL_W-1:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      s_q <= '0;
      s_q.pc <= RESET_VEC;
      s_q.status <= STATUS_RST;
      s_q.pointer <= POINTER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs; upper counter bits dropped so fetches alias
  assign PC = s_q.pc;
  // Size cast zero-fills the bits above the implemented words
  assign PROG_ADDR = PROG_LARGE_W'(s_q.pc[PW-1:0]);
  assign PROG_RD = RESETN;
  assign INSTR = s_q.instr;
  assign DATA_RDATA = s_q.rdata;
  assign DATA_FULL_ADDR = s_q.full;
  assign BANK = bank_sel;
  assign STATUS = s_q.status;
  assign POINTER = s_q.pointer;
  assign EE_ADDR = s_q.ee_ptr;
endmodule // core_memory_map

/* shared/memmap_pkg.sv */
// Package for the core memory address map: widths, vectors, bank layout.
// Assumes one 100 MHz core clock and a core that drives the map each cycle.
package memmap_pkg;

  // Program side
  localparam int PC_W = 13;                        // Program counter width
  localparam int INSTR_W = 14;                     // Program word width
  localparam int PROG_SMALL_W = 10;                // 1K words implemented
  localparam int PROG_LARGE_W = 11;                // 2K words implemented
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000; // Fetch start after reset
  localparam logic [PC_W-1:0] INTR_VEC = 13'h0004;  // Interrupt entry

  // Data side
  localparam int LOCAL_W = 7;                      // Address inside a bank
  localparam int DADDR_W = 9;                      // Bank select plus local
  localparam int DATA_W = 8;
  localparam int STATUS_BANK_HI = 6;               // Upper bank select bit
  localparam int STATUS_BANK_LO = 5;               // Lower bank select bit
  localparam logic [LOCAL_W-1:0] BANK_TOP = 7'h7f;  // Last local address
  localparam logic [LOCAL_W-1:0] GPR_BASE = 7'h20;  // First static RAM address
  localparam logic [LOCAL_W-1:0] INDIRECT_LOC = 7'h00; // Indirect access slot
  localparam logic [LOCAL_W-1:0] STATUS_LOC = 7'h03;   // Mirrored status
  localparam logic [LOCAL_W-1:0] POINTER_LOC = 7'h04;  // Mirrored pointer
  localparam logic [LOCAL_W-1:0] PCLATH_LOC = 7'h0a;   // Mirrored latch
  localparam logic [LOCAL_W-1:0] INTCTL_LOC = 7'h0b;   // Mirrored int control
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;    // Status after reset
  localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;   // Pointer after reset

  // Data EEPROM pointer widths
  localparam int EE_SMALL_W = 7;                   // 00h-7Fh
  localparam int EE_LARGE_W = 8;                   // 00h-FFh

  // Decoded target of a data access
  typedef enum logic [1:0] {
    TGT_SFR,
    TGT_GPR,
    TGT_NONE
  } target_t;

  // Data access request from the core
  typedef struct packed {
    logic rd;
    logic wr;
    logic [LOCAL_W-1:0] local_addr;
    logic [DATA_W-1:0] wdata;
  } data_req_t;

  // Decoded data access
  typedef struct packed {
    target_t target;
    logic [DADDR_W-1:0] full_addr;
    logic [LOCAL_W-1:0] canon_addr;
    logic indirect;
  } data_dec_t;

  // Program fetch request
  typedef struct packed {
    logic fetch;
    logic [PC_W-1:0] pc;
  } prog_req_t;

endpackage

/* tb/memmap_chk.sv */
// Checker on the ports of the core memory map.
// Assumes a bind from the bench top that passes the variant parameter on.
`timescale 1ns/1ps
module memmap_chk #(
  parameter bit LARGE = 1'b1 // Variant of the watched instance
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input memmap_pkg::prog_req_t PROG_REQ,
  input wire logic INTR_TAKE,
  input wire logic [12:0] PC,
  input wire logic [10:0] PROG_ADDR,
  input wire logic [13:0] PROG_WORD,
  input wire logic [13:0] INSTR,
  input memmap_pkg::data_req_t DATA_REQ,
  input wire logic [7:0] DATA_RDATA,
  input wire logic [8:0] DATA_FULL_ADDR,
  input wire logic [1:0] BANK,
  input wire logic [7:0] STATUS,
  input wire logic [7:0] POINTER,
  input wire logic EE_PTR_WR,
  input wire logic [7:0] EE_PTR_WDATA,
  input wire logic [7:0] EE_ADDR
);
  import memmap_pkg::*;
  ////////////////////////////////
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  wire acc = DATA_REQ.rd | DATA_REQ.wr; // Any data access
  wire ind = DATA_REQ.local_addr == INDIRECT_LOC; // Slot 00h goes via pointer
  wire [1:0] wbank = DATA_REQ.wdata[6:5]; // Bank bits being written
  wire [8:0] dir_addr = {BANK, DATA_REQ.local_addr};
  wire [8:0] ind_addr = {STATUS[6], POINTER};
  ////////////////////////////////
  a_intr_vector: assert property (INTR_TAKE |=> PC == INTR_VEC)
    else $error("pc missed interrupt entry");
  a_fetch_load: assert property (PROG_REQ.fetch && !INTR_TAKE |=>
    PC == $past(PROG_REQ.pc) && INSTR == $past(PROG_WORD)) else $error("fetch bad");
  a_fetch_alias: assert property (PROG_ADDR == (LARGE ? PC[10:0] : {1'b0, PC[9:0]}))
    else $error("alias bad");
  a_bank_bits: assert property (BANK == {STATUS[6], STATUS[5]})
    else $error("bank bits bad");
  a_bank_write: assert property (DATA_REQ.wr && DATA_REQ.local_addr == STATUS_LOC
    |=> BANK == $past(wbank)) else $error("status write lost");
  a_direct_addr: assert property (acc && !ind |=> DATA_FULL_ADDR == $past(dir_addr))
    else $error("direct address bad");
  a_indirect_addr: assert property (acc && ind |=> DATA_FULL_ADDR == $past(ind_addr))
    else $error("indirect address bad");
  a_status_read: assert property (DATA_REQ.rd && DATA_REQ.local_addr == STATUS_LOC
    |=> DATA_RDATA == $past(STATUS)) else $error("status read bad");
  a_ee_pointer: assert property (EE_PTR_WR |=> EE_ADDR ==
    (LARGE ? $past(EE_PTR_WDATA) : {1'b0, $past(EE_PTR_WDATA[6:0])}))
    else $error("eeprom pointer bad");
  a_ram_readback: assert property (DATA_REQ.wr && DATA_REQ.local_addr >= GPR_BASE
    ##1 DATA_REQ.rd && DATA_REQ.local_addr == $past(DATA_REQ.local_addr)
    |=> DATA_RDATA == $past(DATA_REQ.wdata, 2)) else $error("ram readback bad");
  cover property (INTR_TAKE);
  cover property (acc && ind);
  cover property (BANK == 2'h3);
endmodule // memmap_chk

/* tb/tb_top.sv */
// Self-checking bench for the core memory map, random with fixed seed.
// Assumes the default larger variant; the checker is bound below.
`timescale 1ns/1ps
module tb_top;
  import memmap_pkg::*;
  logic CORE_CLK = 0, RESETN = 0, INTR_TAKE = 0, EE_PTR_WR = 0;
  prog_req_t PROG_REQ = '0;
  data_req_t DATA_REQ = '0;
  logic [13:0] PROG_WORD = '0, INSTR;
  logic [7:0] EE_PTR_WDATA = '0, DATA_RDATA, STATUS, POINTER, EE_ADDR, d, p;
  logic [12:0] PC;
  logic [10:0] PROG_ADDR;
  logic [8:0] DATA_FULL_ADDR;
  logic [1:0] BANK;
  logic PROG_RD;
  logic [10:0] s_prog_addr; // Program address of the smaller variant
  logic [7:0] s_ee_addr; // EEPROM pointer of the smaller variant
  int seed = 11, n_mismatch = 0, cmp_count = 0;
  core_memory_map DUT (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PROG_REQ(PROG_REQ), .INTR_TAKE(INTR_TAKE),
    .PC(PC), .PROG_ADDR(PROG_ADDR), .PROG_RD(PROG_RD), .PROG_WORD(PROG_WORD),
    .INSTR(INSTR), .DATA_REQ(DATA_REQ), .DATA_RDATA(DATA_RDATA),
    .DATA_FULL_ADDR(DATA_FULL_ADDR), .BANK(BANK), .STATUS(STATUS), .POINTER(POINTER),
    .EE_PTR_WR(EE_PTR_WR), .EE_PTR_WDATA(EE_PTR_WDATA), .EE_ADDR(EE_ADDR)
  );
  // Smaller variant on the same stimulus: 1K program words, 128-byte EEPROM
  core_memory_map #(.LARGE(1'b0)) DUT_S (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PROG_REQ(PROG_REQ), .INTR_TAKE(INTR_TAKE),
    .PC(), .PROG_ADDR(s_prog_addr), .PROG_RD(), .PROG_WORD(PROG_WORD), .INSTR(),
    .DATA_REQ(DATA_REQ), .DATA_RDATA(), .DATA_FULL_ADDR(), .BANK(), .STATUS(), .POINTER(),
    .EE_PTR_WR(EE_PTR_WR), .EE_PTR_WDATA(EE_PTR_WDATA), .EE_ADDR(s_ee_addr)
  );
  ////////////////////////////////
  // Fetches wrap modulo the implemented words
  function automatic logic [10:0] alias_of(logic [12:0] a, int words);
    return 11'(a % words);
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One data access; held until the caller changes it, so no double drive
  task automatic acc(logic r, logic w, logic [6:0] a, logic [7:0] v);
    DATA_REQ = '{r, w, a, v};
    @(negedge CORE_CLK);
  endtask
  task automatic summarize();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////
  initial forever #5 CORE_CLK = ~CORE_CLK;
  // Guard against a hang
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (16) @(negedge CORE_CLK);
    chk(PC, RESET_VEC);
    RESETN = 1;
    DATA_REQ = '{1'b1, 1'b0, STATUS_LOC, 8'h00};
    // Eight aliases of 020h first, then random counters
    for (int k = 0; k < 24; k++) begin
      PROG_REQ = '{1'b1, k < 8 ? {k[2:0], 10'h020} : 13'($random(seed))};
      PROG_WORD = 14'($random(seed));
      @(negedge CORE_CLK);
      chk(PC, PROG_REQ.pc);
      chk(PROG_ADDR, alias_of(PROG_REQ.pc, 2048));
      chk(s_prog_addr, alias_of(PROG_REQ.pc, 1024));
      chk(INSTR, PROG_WORD);
      chk(DATA_RDATA, STATUS_RST);
    end
    // Interrupt wins over a fetch still asserted
    INTR_TAKE = 1;
    @(negedge CORE_CLK);
    INTR_TAKE = 0;
    PROG_REQ = '0;
    chk(PC, INTR_VEC);
    for (int b = 0; b < 4; b++) begin
      d = 8'($random(seed));
      p = 8'($random(seed));
      acc(0, 1, STATUS_LOC, {1'b0, b[1:0], 5'h00});
      chk(BANK, b[1:0]);
      chk(STATUS, {1'b0, b[1:0], 5'h00});
      acc(0, 1, 7'(127 - b), d);
      acc(1, 0, 7'(127 - b), 0);
      chk(DATA_RDATA, d);
      chk(DATA_FULL_ADDR, {b[1:0], 7'(127 - b)});
      acc(1, 0, STATUS_LOC, 0);
      chk(DATA_RDATA[6:5], b[1:0]);
      acc(0, 1, POINTER_LOC, p);
      chk(POINTER, p);
      acc(1, 0, INDIRECT_LOC, 0);
      chk(DATA_FULL_ADDR, {b[1], p});
    end
    DATA_REQ = '0;
    // Pointer held on, top address first
    EE_PTR_WR = 1;
    for (int k = 0; k < 8; k++) begin
      EE_PTR_WDATA = k == 0 ? 8'hff : 8'($random(seed));
      @(negedge CORE_CLK);
      chk(EE_ADDR, EE_PTR_WDATA);
      chk(s_ee_addr, {1'b0, EE_PTR_WDATA[6:0]});
    end
    EE_PTR_WR = 0;
    // Reset in mid-run: counter was at the interrupt entry, bank at 3
    RESETN = 0;
    @(negedge CORE_CLK);
    chk(PC, RESET_VEC);
    chk(STATUS, STATUS_RST);
    chk(BANK, 2'h0);
    chk(PROG_RD, 1'b0);
    RESETN = 1;
    @(negedge CORE_CLK);
    chk(PROG_RD, 1'b1);
    chk(PC, RESET_VEC);
    summarize();
  end
endmodule // tb_top
bind core_memory_map memmap_chk #(.LARGE(LARGE)) chk_i (.*);
